// ---- tb/lmcd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module lmcd_props (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic       frame_start
);
  logic [1:0] cnt_r;
  logic       node_r;
  logic [7:0] sum_r;
  logic [8:0] add;
  logic       last;
  // The running sum folds its carry per byte, as the enhanced checksum does.
  assign add = {1'b0, sum_r} + {1'b0, byte_data};
  assign last = byte_valid && !frame_start && cnt_r == (node_r ? 2'd3 : 2'd2);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 2'h0;
    else if (frame_start) cnt_r <= 2'h1;
    else if (byte_valid) cnt_r <= cnt_r + 2'h1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) node_r <= 1'b0;
    else if (frame_start) node_r <= byte_data == 8'hc1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sum_r <= 8'h00;
    else if (frame_start) sum_r <= byte_data;
    else if (byte_valid) sum_r <= add[7:0] + {7'h00, add[8]};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_start_has_byte: assert property (frame_start |-> byte_valid)
    else $error("frame start without a byte");
  a_pid_parity: assert property (frame_start |->
    byte_data[6] == ^{byte_data[0], byte_data[1], byte_data[2], byte_data[4]}
    && byte_data[7] == ~^{byte_data[1], byte_data[3], byte_data[4],
    byte_data[5]}) else $error("identifier parity wrong");
  a_node_length: assert property (frame_start && byte_data == 8'hc1 |=>
    byte_valid [*3] ##1 (!byte_valid || frame_start))
    else $error("node frame length wrong");
  a_group_length: assert property (frame_start && byte_data != 8'hc1 |=>
    byte_valid [*2] ##1 (!byte_valid || frame_start))
    else $error("group frame length wrong");
  a_node_cmd: assert property (frame_start && byte_data == 8'hc1 |=>
    ##1 byte_data inside {8'h04, 8'h05, 8'h06}) else $error("node cmd bad");
  a_group_cmd: assert property (frame_start && byte_data != 8'hc1 |=>
    byte_data inside {8'h04, 8'h05, 8'h06}) else $error("group cmd bad");
  a_checksum_ok: assert property (last |-> byte_data == ~sum_r)
    else $error("checksum byte wrong");
  a_first_is_pid: assert property ($rose(byte_valid) |-> frame_start)
    else $error("frame does not open with identifier");
endmodule
`default_nettype wire

// ---- tb/lmcd_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module lin_motion_command_decoder_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_group = 1'b0;
  logic [7:0]  req_cmd = 8'h00;
  logic [7:0]  req_nad = 8'h00;
  logic [5:0]  req_group_pid = 6'h02;
  logic [7:0]  node_address = 8'h00;
  logic [5:0]  group_pid = 6'h02;
  logic [10:0] safe_position = 11'h000;
  logic        safe_position_enable = 1'b0;
  logic        coil_fault = 1'b0;
  logic        motor_moving = 1'b0;
  logic        step_pulse = 1'b0;
  logic        step_dir = 1'b1;
  logic        lost_step_clear = 1'b0;
  logic        internal_safe_req = 1'b0;
  logic        bemf_coil_y = 1'b0;
  logic        req_ready, done, shutdown, lost_step_flag, reference_done;
  logic        go_to_safe_position_cmd, immediate_halt_cmd, zero_position_cmd;
  logic        bemf_coil_bit, s2_safe, s2_halt, s2_zero, ref_exp;
  logic [15:0] actual_position, target_position, act_exp, tgt_exp;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          seed = 25;
  lmcd_link_if link ();
  lmcd_link_if link2 ();
  always #5 ref_clk = ~ref_clk;
  lmcd_master u_lmcd_master (.ref_clk, .rst_n, .link(link), .req_valid,
    .req_cmd, .req_group, .req_nad, .req_group_pid, .req_ready, .done);
  lmcd_slave u_lmcd_slave (.ref_clk, .rst_n, .link(link), .node_address,
    .group_pid, .safe_position, .safe_position_enable, .coil_fault,
    .motor_moving, .step_pulse, .step_dir, .lost_step_clear,
    .internal_safe_req, .bemf_coil_y, .go_to_safe_position_cmd,
    .immediate_halt_cmd, .zero_position_cmd, .shutdown, .lost_step_flag,
    .reference_done, .bemf_coil_bit, .actual_position, .target_position);
  // Second end is fed by the bench so that broken frames can be sent.
  lmcd_slave u_lmcd_slave_2 (.ref_clk, .rst_n, .link(link2), .node_address,
    .group_pid, .safe_position, .safe_position_enable, .coil_fault,
    .motor_moving, .step_pulse, .step_dir, .lost_step_clear,
    .internal_safe_req, .bemf_coil_y, .go_to_safe_position_cmd(s2_safe),
    .immediate_halt_cmd(s2_halt), .zero_position_cmd(s2_zero), .shutdown(),
    .lost_step_flag(), .reference_done(), .bemf_coil_bit(),
    .actual_position(), .target_position());
  lmcd_props u_props (.ref_clk, .rst_n, .byte_valid(link.byte_valid),
    .byte_data(link.byte_data), .frame_start(link.frame_start));
  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] hits(input logic [7:0] c, input logic g,
    input logic [7:0] n, input logic [5:0] p);
    logic h;
    h = g ? p == group_pid : (n == node_address || n == 8'h7f);
    return {h && c == 8'h04, h && c == 8'h05, h && c == 8'h06};
  endfunction
  function automatic logic [7:0] csum(input logic [7:0] q[$]);
    logic [8:0] s;
    s = 9'h000;
    foreach (q[i]) begin
      s = {1'b0, s[7:0]} + {1'b0, q[i]};
      s = {1'b0, s[7:0]} + {8'h00, s[8]};
    end
    return ~s[7:0];
  endfunction
  task automatic send(input logic [7:0] c, input logic g, input logic [7:0] n,
    input logic [5:0] p);
    int k;
    chk(16'(req_ready), 16'h1);
    @(posedge ref_clk);
    req_cmd <= c;
    req_group <= g;
    req_nad <= n;
    req_group_pid <= p;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge ref_clk);
    if (k == 20) failures++;
    @(negedge ref_clk);
  endtask
  task automatic raw(input logic [7:0] pid, n, c, input logic has_n,
    input logic [7:0] flip);
    logic [7:0] b[$];
    b = {pid, c};
    if (has_n) b = {pid, n, c};
    b.push_back(csum(b) ^ flip);
    foreach (b[i]) begin
      @(posedge ref_clk);
      link2.byte_valid <= 1'b1;
      link2.frame_start <= i == 0;
      link2.byte_data <= b[i];
    end
    @(posedge ref_clk);
    link2.byte_valid <= 1'b0;
    link2.frame_start <= 1'b0;
    // A released line shows the inverse so stale data cannot pass.
    link2.byte_data <= ~b[b.size()-1];
    @(negedge ref_clk);
  endtask
  task automatic step5();
    repeat (5) begin
      @(posedge ref_clk);
      step_pulse <= 1'b1;
      @(posedge ref_clk);
      step_pulse <= 1'b0;
    end
    act_exp = act_exp + 16'h0005;
    repeat (2) @(negedge ref_clk);
  endtask
  initial begin
    logic [7:0] c, n;
    logic [5:0] p;
    logic [2:0] e;
    logic       g;
    link2.byte_valid = 1'b0;
    link2.frame_start = 1'b0;
    link2.byte_data = 8'h00;
    act_exp = 16'h0000;
    tgt_exp = 16'h0000;
    ref_exp = 1'b0;
    node_address = 8'($random(seed)) & 8'h3f;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      @(posedge ref_clk);
      bemf_coil_y <= b[0];
      repeat (2) @(negedge ref_clk);
      chk(16'(bemf_coil_bit), 16'(b));
    end
    $display("coil bit test done");
    step5();
    for (int i = 0; i < 40; i++) begin
      c = 8'h04 + 8'($unsigned($random(seed)) % 3);
      g = 1'($random(seed));
      p = 6'h02 + 6'($random(seed) & 1);
      n = 8'($random(seed));
      if (i % 3 == 0) n = 8'h7f;
      if (i % 3 == 1) n = node_address;
      @(posedge ref_clk);
      safe_position <= 11'($random(seed));
      safe_position_enable <= 1'($random(seed));
      @(negedge ref_clk);
      e = hits(c, g, n, p);
      send(c, g, n, p);
      chk(16'({go_to_safe_position_cmd, immediate_halt_cmd,
        zero_position_cmd}), 16'(e));
      if (e[2]) tgt_exp = {5'h00, safe_position};
      if (e[1]) tgt_exp = act_exp;
      if (e[0]) begin
        act_exp = 16'h0000;
        tgt_exp = 16'h0000;
        ref_exp = 1'b1;
      end
      @(negedge ref_clk);
      chk(target_position, tgt_exp);
      chk(actual_position, act_exp);
      chk(16'(reference_done), 16'(ref_exp));
    end
    $display("command frame test done");
    raw(8'hc1, node_address, 8'h05, 1'b1, 8'h00);
    chk(16'({s2_safe, s2_halt, s2_zero}), 16'h2);
    raw(8'hc1, node_address, 8'h05, 1'b1, 8'h01);
    chk(16'({s2_safe, s2_halt, s2_zero}), 16'h0);
    raw(8'hc1, node_address, 8'h07, 1'b1, 8'h00);
    chk(16'({s2_safe, s2_halt, s2_zero}), 16'h0);
    raw(8'hc1, node_address ^ 8'h01, 8'h06, 1'b1, 8'h00);
    chk(16'({s2_safe, s2_halt, s2_zero}), 16'h0);
    raw(8'h42, 8'h00, 8'h06, 1'b0, 8'h00);
    chk(16'({s2_safe, s2_halt, s2_zero}), 16'h1);
    $display("broken frame test done");
    @(posedge ref_clk);
    internal_safe_req <= 1'b1;
    @(posedge ref_clk);
    internal_safe_req <= 1'b0;
    @(negedge ref_clk);
    chk(16'(go_to_safe_position_cmd), 16'h1);
    $display("internal safe request test done");
    step5();
    @(posedge ref_clk);
    motor_moving <= 1'b1;
    coil_fault <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(16'(immediate_halt_cmd), 16'h1);
    @(negedge ref_clk);
    chk(16'(shutdown), 16'h1);
    chk(16'(lost_step_flag), 16'h1);
    @(posedge ref_clk);
    motor_moving <= 1'b0;
    coil_fault <= 1'b0;
    lost_step_clear <= 1'b1;
    @(posedge ref_clk);
    lost_step_clear <= 1'b0;
    coil_fault <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(target_position, act_exp);
    chk(16'({shutdown, lost_step_flag}), 16'h2);
    $display("coil fault test done");
    final_report();
  end
endmodule
`default_nettype wire

// ---- verilog/lmcd_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Byte-level frame link; the checksum byte closes each frame.
interface lmcd_link_if;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       frame_start;

  modport master (
    output byte_valid,
    output byte_data,
    output frame_start
  );

  modport slave (
    input byte_valid,
    input byte_data,
    input frame_start
  );
endinterface
`default_nettype wire

// ---- verilog/lmcd_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module lmcd_master (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  lmcd_link_if.master      link,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_cmd,
  input  wire logic        req_group,
  input  wire logic [7:0]  req_nad,
  input  wire logic [5:0]  req_group_pid,
  output logic             req_ready,
  output logic             done
);

  lmcd_pkg::lmcd_rx_state_t state_r;
  logic [7:0] sum_r;
  logic [7:0] cmd_r;
  logic [7:0] nad_r;
  logic [7:0] pid_b;

  // Group frames drop the address byte; the group code is assigned beforehand.
  assign pid_b = lmcd_pkg::lmcd_pid_byte(req_group ? req_group_pid
                                                   : lmcd_pkg::PID_NODE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r          <= lmcd_pkg::LMCD_IDLE;
      sum_r            <= 8'h00;
      cmd_r            <= 8'h00;
      nad_r            <= 8'h00;
      req_ready        <= 1'b1;
      done             <= 1'b0;
      link.byte_valid  <= 1'b0;
      link.byte_data   <= 8'h00;
      link.frame_start <= 1'b0;
    end else begin
      link.byte_valid  <= 1'b0;
      link.frame_start <= 1'b0;
      done             <= 1'b0;
      case (state_r)
        lmcd_pkg::LMCD_IDLE: begin
          if (req_valid && req_ready) begin
            req_ready        <= 1'b0;
            link.frame_start <= 1'b1;
            link.byte_valid  <= 1'b1;
            link.byte_data   <= pid_b;
            sum_r            <= pid_b;
            cmd_r            <= req_cmd;
            nad_r            <= req_nad;
            state_r          <= req_group ? lmcd_pkg::LMCD_CMD
                                          : lmcd_pkg::LMCD_NAD;
          end
        end
        lmcd_pkg::LMCD_NAD: begin
          link.byte_valid <= 1'b1;
          link.byte_data  <= nad_r;
          sum_r           <= lmcd_pkg::lmcd_sum_add(sum_r, nad_r);
          state_r         <= lmcd_pkg::LMCD_CMD;
        end
        lmcd_pkg::LMCD_CMD: begin
          link.byte_valid <= 1'b1;
          link.byte_data  <= cmd_r;
          sum_r           <= lmcd_pkg::lmcd_sum_add(sum_r, cmd_r);
          state_r         <= lmcd_pkg::LMCD_SUM;
        end
        default: begin
          link.byte_valid <= 1'b1;
          link.byte_data  <= ~sum_r;
          done            <= 1'b1;
          req_ready       <= 1'b1;
          state_r         <= lmcd_pkg::LMCD_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- verilog/lmcd_pkg.sv ----
package lmcd_pkg;

  localparam logic [7:0] CMD_SAFE_POS   = 8'h04;
  localparam logic [7:0] CMD_HALT       = 8'h05;
  localparam logic [7:0] CMD_ZERO_POS   = 8'h06;
  localparam logic [7:0] NAD_BROADCAST  = 8'h7f;
  localparam logic [5:0] PID_NODE       = 6'h01;
  localparam logic [5:0] PID_GROUP      = 6'h02;
  localparam logic       COIL_X         = 1'b0;
  localparam logic       COIL_Y         = 1'b1;
  localparam logic [15:0] POS_RESET     = 16'h0000;
  localparam logic [10:0] SAFE_RESET    = 11'h000;
  localparam logic [7:0] NAD_RESET      = 8'h00;
  localparam logic [5:0] GROUP_RESET    = 6'h02;

  typedef enum logic [1:0] {
    LMCD_IDLE,
    LMCD_NAD,
    LMCD_CMD,
    LMCD_SUM
  } lmcd_rx_state_t;

  typedef enum logic [1:0] {
    LMCD_OP_SAFE,
    LMCD_OP_HALT,
    LMCD_OP_ZERO
  } lmcd_op_t;

  function automatic logic [7:0] lmcd_sum_add(input logic [7:0] acc,
                                              input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic [7:0] lmcd_pid_byte(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  function automatic logic lmcd_known_cmd(input logic [7:0] c);
    return (c == CMD_SAFE_POS) || (c == CMD_HALT) || (c == CMD_ZERO_POS);
  endfunction

endpackage

// ---- verilog/lmcd_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module lmcd_slave (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  lmcd_link_if.slave       link,
  input  wire logic [7:0]  node_address,
  input  wire logic [5:0]  group_pid,
  input  wire logic [10:0] safe_position,
  input  wire logic        safe_position_enable,
  input  wire logic        coil_fault,
  input  wire logic        motor_moving,
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic        lost_step_clear,
  input  wire logic        internal_safe_req,
  input  wire logic        bemf_coil_y,
  output logic             go_to_safe_position_cmd,
  output logic             immediate_halt_cmd,
  output logic             zero_position_cmd,
  output logic             shutdown,
  output logic             lost_step_flag,
  output logic             reference_done,
  output logic             bemf_coil_bit,
  output logic [15:0]      actual_position,
  output logic [15:0]      target_position
);

  lmcd_pkg::lmcd_rx_state_t state_r;
  logic [7:0] sum_r;
  logic [7:0] cmd_r;
  logic       addr_ok_r;
  logic       frame_ok;
  logic       fault_d_r;
  logic       halt_pend_r;
  logic       halt_ev;
  logic       fault_rise;

  // The identifier byte picks the format: the node identifier expects an address byte, the group identifier does not.
  // Only the byte marked as frame start is read as an identifier, so a
  // data byte that looks like one can never open a frame.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= lmcd_pkg::LMCD_IDLE;
      sum_r     <= 8'h00;
      cmd_r     <= 8'h00;
      addr_ok_r <= 1'b0;
    end else if (link.byte_valid && link.frame_start) begin
      sum_r <= link.byte_data;
      if (link.byte_data == lmcd_pkg::lmcd_pid_byte(lmcd_pkg::PID_NODE)) begin
        state_r <= lmcd_pkg::LMCD_NAD;
      end else if (link.byte_data == lmcd_pkg::lmcd_pid_byte(group_pid)) begin
        addr_ok_r <= 1'b1;
        state_r   <= lmcd_pkg::LMCD_CMD;
      end else begin
        state_r <= lmcd_pkg::LMCD_IDLE;
      end
    end else if (link.frame_start) begin
      state_r <= lmcd_pkg::LMCD_IDLE;
    end else if (link.byte_valid) begin
      case (state_r)
        lmcd_pkg::LMCD_IDLE: begin
          state_r <= lmcd_pkg::LMCD_IDLE;
        end
        lmcd_pkg::LMCD_NAD: begin
          sum_r     <= lmcd_pkg::lmcd_sum_add(sum_r, link.byte_data);
          addr_ok_r <= (link.byte_data == node_address) ||
                       (link.byte_data == lmcd_pkg::NAD_BROADCAST);
          state_r   <= lmcd_pkg::LMCD_CMD;
        end
        lmcd_pkg::LMCD_CMD: begin
          sum_r   <= lmcd_pkg::lmcd_sum_add(sum_r, link.byte_data);
          cmd_r   <= link.byte_data;
          state_r <= lmcd_pkg::LMCD_SUM;
        end
        default: begin
          state_r <= lmcd_pkg::LMCD_IDLE;
        end
      endcase
    end
  end

  // Enhanced checksum: all bytes including the PID plus the checksum add to ff.
  assign frame_ok = link.byte_valid && !link.frame_start &&
                    (state_r == lmcd_pkg::LMCD_SUM) && addr_ok_r &&
                    lmcd_pkg::lmcd_known_cmd(cmd_r) &&
                    (lmcd_pkg::lmcd_sum_add(sum_r, link.byte_data) == 8'hff);

  assign fault_rise = coil_fault && !fault_d_r;
  assign halt_ev    = fault_rise ||
                      (frame_ok && cmd_r == lmcd_pkg::CMD_HALT);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_to_safe_position_cmd <= 1'b0;
      immediate_halt_cmd      <= 1'b0;
      zero_position_cmd       <= 1'b0;
    end else begin
      // Safe moves run whatever the enable says; safe_position_enable gates no command at all.
      go_to_safe_position_cmd <= internal_safe_req ||
        (frame_ok && cmd_r == lmcd_pkg::CMD_SAFE_POS);
      immediate_halt_cmd <= halt_ev;
      zero_position_cmd  <= frame_ok && cmd_r == lmcd_pkg::CMD_ZERO_POS;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_d_r <= 1'b0;
      shutdown  <= 1'b0;
    end else begin
      fault_d_r <= coil_fault;
      if (fault_rise) begin
        shutdown <= 1'b1;
      end else if (!coil_fault) begin
        shutdown <= 1'b0;
      end
    end
  end

  // A fresh fault while motor_moving is high wins over a clear arriving in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_step_flag <= 1'b0;
    end else if (fault_rise && motor_moving) begin
      lost_step_flag <= 1'b1;
    end else if (lost_step_clear) begin
      lost_step_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_done <= 1'b0;
    end else if (frame_ok && cmd_r == lmcd_pkg::CMD_ZERO_POS) begin
      reference_done <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bemf_coil_bit <= lmcd_pkg::COIL_X;
    end else begin
      bemf_coil_bit <= bemf_coil_y ? lmcd_pkg::COIL_Y
                                   : lmcd_pkg::COIL_X;
    end
  end

  // The copy waits for rest so a decelerating motor keeps its final step.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_pend_r     <= 1'b0;
      actual_position <= lmcd_pkg::POS_RESET;
      target_position <= lmcd_pkg::POS_RESET;
    end else if (frame_ok && cmd_r == lmcd_pkg::CMD_ZERO_POS) begin
      // A coil fault in the same cycle still gets its copy later.
      halt_pend_r     <= halt_ev;
      actual_position <= lmcd_pkg::POS_RESET;
      target_position <= lmcd_pkg::POS_RESET;
    end else begin
      if (step_pulse) begin
        actual_position <= step_dir ? actual_position + 16'h0001
                                    : actual_position - 16'h0001;
      end
      if (halt_ev) begin
        halt_pend_r <= 1'b1;
      end else if (halt_pend_r && !motor_moving && !step_pulse) begin
        halt_pend_r     <= 1'b0;
        target_position <= actual_position;
      end else if (frame_ok && cmd_r == lmcd_pkg::CMD_SAFE_POS) begin
        target_position <= {5'h00, safe_position};
      end
    end
  end

endmodule
`default_nettype wire
